/* rtl/counter_array_pkg.sv */
package counter_array_pkg;
  // register addresses on the special function register bus
  localparam logic [7:0] ADDR_CTL    = 8'hD8;
  localparam logic [7:0] ADDR_MD     = 8'hD9;
  localparam logic [7:0] ADDR_CNT_LO = 8'hF9;
  localparam logic [7:0] ADDR_CNT_HI = 8'hFA;
  localparam logic [7:0] ADDR_MODE [3] = '{8'hDA, 8'hDB, 8'hDC};
  localparam logic [7:0] ADDR_CPL  [3] = '{8'hFB, 8'hE9, 8'hEB};
  localparam logic [7:0] ADDR_CPH  [3] = '{8'hFC, 8'hE9, 8'hEC};
  // array_control fields
  localparam int CTL_CF = 7;
  localparam int CTL_CR = 6;
  // array_mode fields
  localparam int MD_IDLE   = 7;
  localparam int MD_WATCHDOG_ENABLE   = 6;
  localparam int MD_LOCK   = 5;
  localparam int MD_UNUSED = 4;
  localparam int MD_TB_LSB = 1;
  localparam int MD_ECF    = 0;
  // module_mode fields
  localparam int M_PWM16 = 7;
  localparam int M_ECOM  = 6;
  localparam int M_CAPP  = 5;
  localparam int M_CAPN  = 4;
  localparam int M_MAT   = 3;
  localparam int M_TOG   = 2;
  localparam int M_PWM   = 1;
  localparam int M_ECCF  = 0;
  // reset values
  localparam logic [7:0] RST_CTL  = 8'h00;
  localparam logic [7:0] RST_MD   = 8'h40;
  localparam logic [7:0] RST_BYTE = 8'h00;
  // timebase
  typedef enum logic [2:0] {
    TB_DIV12 = 3'h0,
    TB_DIV4  = 3'h1,
    TB_T0    = 3'h2,
    TB_ECI   = 3'h3,
    TB_SYS   = 3'h4,
    TB_EXT8  = 3'h5
  } timebase_e;
  localparam logic [3:0] PRE_LAST     = 4'hB;
  localparam logic [1:0] DIV4_LAST    = 2'h3;
  localparam logic [2:0] EXT_DIV_LAST = 3'h7;
endpackage

/* rtl/counter_timebase.sv */
`timescale 1ns/1ps
module counter_timebase
  import counter_array_pkg::*;
(
  // clock and reset
  input  wire logic       mclk,
  input  wire logic       rst_n,
  // source selection
  input  wire logic [2:0] sel,
  input  wire logic       timer0_ovf,
  input  wire logic       eci_pin,
  input  wire logic       ext_clk_pin,
  // one pulse per counter step
  output logic            tick_q
);
  logic [3:0] pre_q, pre_d;
  logic [2:0] eci_q, eci_d;
  logic [2:0] ext_q, ext_d;
  logic [2:0] div_q, div_d;
  logic       tick_d;
  logic       ext_rise;

  always_comb
  begin
    pre_d    = (pre_q == PRE_LAST) ? 4'h0 : 4'(pre_q + 4'h1);
    eci_d    = {eci_q[1:0], eci_pin};
    ext_d    = {ext_q[1:0], ext_clk_pin};
    // the divided clock is counted from synchronised edges only
    ext_rise = ext_q[1] & ~ext_q[2];
    div_d    = 3'(div_q + {2'h0, ext_rise});
    case (sel)
      TB_DIV12: tick_d = (pre_q == PRE_LAST);
      TB_DIV4:  tick_d = (pre_q[1:0] == DIV4_LAST);
      TB_T0:    tick_d = timer0_ovf;
      TB_ECI:   tick_d = eci_q[2] & ~eci_q[1];
      TB_SYS:   tick_d = 1'b1;
      TB_EXT8:  tick_d = ext_rise && (div_q == EXT_DIV_LAST);
      default:  tick_d = 1'b0;
    endcase
  end

  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      pre_q  <= 4'h0;
      eci_q  <= 3'h0;
      ext_q  <= 3'h0;
      div_q  <= 3'h0;
      tick_q <= 1'b0;
    end
    else
    begin
      pre_q  <= pre_d;
      eci_q  <= eci_d;
      ext_q  <= ext_d;
      div_q  <= div_d;
      tick_q <= tick_d;
    end
  end
endmodule

/* rtl/capture_compare_unit.sv */
`timescale 1ns/1ps
module capture_compare_unit
  import counter_array_pkg::*;
(
  // clock and reset
  input  wire logic        mclk,
  input  wire logic        rst_n,
  // counter state, events of the previous step
  input  wire logic [15:0] cnt,
  input  wire logic        moved,
  input  wire logic        lo_wrap,
  input  wire logic        wrap,
  // configuration
  input  wire logic [7:0]  mode,
  input  wire logic [15:0] cmp,
  // pin
  input  wire logic        pin_in,
  output logic             cex_q,
  // events
  output logic             match_q,
  output logic             capt_q
);
  logic [2:0] pin_q, pin_d;
  logic       cex_d, match_d, capt_d;
  logic       short_cmp;

  always_comb
  begin
    pin_d = {pin_q[1:0], pin_in};
    // 8-bit pwm and frequency output look at the low byte only
    short_cmp = mode[M_PWM] & (~mode[M_PWM16] | mode[M_TOG]);
    match_d = mode[M_ECOM] & moved & (short_cmp ?
              (cnt[7:0] == cmp[7:0]) : (cnt == cmp));
    capt_d = (mode[M_CAPP] & pin_q[1] & ~pin_q[2]) |
             (mode[M_CAPN] & ~pin_q[1] & pin_q[2]);
    cex_d = cex_q;
    if (mode[M_TOG])
    begin
      if (match_d)
        cex_d = ~cex_q;
    end
    else if (mode[M_PWM])
    begin
      if (!mode[M_ECOM])
        cex_d = 1'b0;
      else if (match_d)
        cex_d = 1'b1;
      else if (mode[M_PWM16] ? wrap : lo_wrap)
        cex_d = 1'b0;
    end
  end

  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      pin_q   <= 3'h0;
      cex_q   <= 1'b0;
      match_q <= 1'b0;
      capt_q  <= 1'b0;
    end
    else
    begin
      pin_q   <= pin_d;
      cex_q   <= cex_d;
      match_q <= match_d;
      capt_q  <= capt_d;
    end
  end
endmodule

/* rtl/counter_array.sv */
`timescale 1ns/1ps
// Contract
// - overflow flag sets on FFFF to 0000 wrap
// - flags stay set until software clears
// - overflow flag raises interrupt when enabled
// - counter steps only while run bit or watchdog enable set
// - match or capture sets module flag
// - module flag raises interrupt when enabled
// - idle suspend stops array during idle
// - watchdog enable turns module 2 watchdog
// - lock keeps watchdog enabled until reset
// - watchdog enable blocks mode register writes, except to the enable and lock bits
// - three-bit field selects counter timebase
// - external input counts falling edges, slowly
// - divided external clock synchronised first
// - unused mode bit reads zero
// - wide pwm select picks 8 or 16
// - comparator enable gates comparison
// - capture on chosen pin edges
// - match with match enable sets flag
// - match with toggle inverts output pin
// - toggle plus pwm gives frequency output
// - pwm enable drives duty-set waveform
// - byte registers reset to zero, except array mode to 40
// - low write clears, high sets comparator
// - watchdog reset on low wrap match
// - watchdog high write reloads counter plus offset
// - watchdog forces run, blocks counter writes
module counter_array
  import counter_array_pkg::*;
(
  // clock and reset
  input  wire logic       mclk,
  input  wire logic       rst_n,
  // special function register bus
  input  wire logic [7:0] sfr_addr,
  input  wire logic       sfr_wr,
  input  wire logic [7:0] sfr_wdata,
  output logic      [7:0] sfr_rdata_q,
  // core status and timebase sources
  input  wire logic       idle_mode,
  input  wire logic       timer0_ovf,
  input  wire logic       eci_pin,
  input  wire logic       ext_clk_pin,
  // module pins
  input  wire logic [2:0] cex_in,
  output logic      [2:0] module_output_pin,
  // requests to the core
  output logic            irq_q,
  output logic            wdt_reset_q
);
  logic        cf_q, cf_d, run_q, run_d;
  logic [2:0]  ccf_q, ccf_d;
  logic        idle_q, idle_d, watchdog_enable_q, watchdog_enable_d, lock_q, lock_d;
  logic [2:0]  tb_q, tb_d;
  logic        ecf_q, ecf_d;
  logic [15:0] cnt_q, cnt_d;
  logic [7:0]  mode_q [3];
  logic [7:0]  mode_d [3];
  logic [7:0]  cpl_q [3];
  logic [7:0]  cpl_d [3];
  logic [7:0]  cph_q [3];
  logic [7:0]  cph_d [3];
  logic        moved_q, moved_d, lo_wrap_q, lo_wrap_d;
  logic        wrap_q, wrap_d;
  logic        irq_d, wdt_reset_d;
  logic [7:0]  rdata_d;
  logic        tick, active, adv;
  logic [2:0]  match, capt;
  logic [7:0]  eff_mode [3];
  logic        ctl_wr, md_wr, cnt_wr;

  assign ctl_wr = sfr_wr && (sfr_addr == ADDR_CTL);
  assign md_wr  = sfr_wr && (sfr_addr == ADDR_MD);
  // counter writes are refused while the watchdog runs
  assign cnt_wr = sfr_wr && !watchdog_enable_q &&
                  (sfr_addr == ADDR_CNT_LO || sfr_addr == ADDR_CNT_HI);
  // the watchdog forces the counter on; idle suspend still applies
  assign active = (run_q | watchdog_enable_q) & ~(idle_q & idle_mode);
  assign adv    = active & tick;

  counter_timebase u_timebase (
    .mclk        (mclk),
    .rst_n       (rst_n),
    .sel         (tb_q),
    .timer0_ovf  (timer0_ovf),
    .eci_pin     (eci_pin),
    .ext_clk_pin (ext_clk_pin),
    .tick_q      (tick)
  );

  genvar g;
  generate
    for (g = 0; g < 3; g++)
    begin : g_mod
      // under the watchdog module 2 does no capture, compare or pwm
      assign eff_mode[g] = (g == 2 && watchdog_enable_q) ? 8'h00 : mode_q[g];
      capture_compare_unit u_ccu (
        .mclk    (mclk),
        .rst_n   (rst_n),
        .cnt     (cnt_q),
        .moved   (moved_q),
        .lo_wrap (lo_wrap_q),
        .wrap    (wrap_q),
        .mode    (eff_mode[g]),
        .cmp     ({cph_q[g], cpl_q[g]}),
        .pin_in  (cex_in[g]),
        .cex_q   (module_output_pin[g]),
        .match_q (match[g]),
        .capt_q  (capt[g])
      );
    end
  endgenerate

  always_comb
  begin
    cf_d   = cf_q;
    run_d  = run_q;
    ccf_d  = ccf_q;
    idle_d = idle_q;
    watchdog_enable_d = watchdog_enable_q;
    lock_d = lock_q;
    tb_d   = tb_q;
    ecf_d  = ecf_q;
    cnt_d  = cnt_q;
    mode_d = mode_q;
    cpl_d  = cpl_q;
    cph_d  = cph_q;
    wdt_reset_d = 1'b0;
    if (ctl_wr)
    begin
      cf_d  = sfr_wdata[CTL_CF];
      run_d = sfr_wdata[CTL_CR];
      ccf_d = sfr_wdata[2:0];
      // writing one to module 2 flag under the watchdog forces reset
      wdt_reset_d = watchdog_enable_q & sfr_wdata[2];
    end
    if (md_wr)
    begin
      if (!watchdog_enable_q)
      begin
        idle_d = sfr_wdata[MD_IDLE];
        tb_d   = sfr_wdata[MD_TB_LSB+:3];
        ecf_d  = sfr_wdata[MD_ECF];
      end
      // only the enable and lock bits move while the watchdog runs
      if (!lock_q)
        watchdog_enable_d = sfr_wdata[MD_WATCHDOG_ENABLE] | sfr_wdata[MD_LOCK];
      lock_d = lock_q | sfr_wdata[MD_LOCK];
    end
    if (adv)
      cnt_d = 16'(cnt_q + 16'h0001);
    if (cnt_wr && sfr_addr == ADDR_CNT_LO)
      cnt_d[7:0] = sfr_wdata;
    if (cnt_wr && sfr_addr == ADDR_CNT_HI)
      cnt_d[15:8] = sfr_wdata;
    for (int i = 0; i < 3; i++)
    begin
      if (sfr_wr && sfr_addr == ADDR_MODE[i] && !(i == 2 && watchdog_enable_q))
        mode_d[i] = sfr_wdata;
      if (sfr_wr && sfr_addr == ADDR_CPL[i])
      begin
        cpl_d[i] = sfr_wdata;
        if (!(i == 2 && watchdog_enable_q))
          mode_d[i][M_ECOM] = 1'b0;
      end
      // where both bytes share an address the low byte wins
      else if (sfr_wr && sfr_addr == ADDR_CPH[i])
      begin
        if (i == 2 && watchdog_enable_q)
          cph_d[i] = 8'(cnt_q[15:8] + cpl_q[i]);
        else
        begin
          cph_d[i] = sfr_wdata;
          mode_d[i][M_ECOM] = 1'b1;
        end
      end
      // 8-bit pwm reloads the low byte from the high byte
      if (mode_q[i][M_PWM] && !mode_q[i][M_PWM16] && !mode_q[i][M_TOG]
          && adv && cnt_q[7:0] == 8'hFF && !(i == 2 && watchdog_enable_q))
        cpl_d[i] = cph_q[i];
      // frequency output steps its next edge by the high byte
      if (match[i] && mode_q[i][M_PWM] && mode_q[i][M_TOG])
        cpl_d[i] = 8'(cpl_q[i] + cph_q[i]);
      if (capt[i])
      begin
        cpl_d[i] = cnt_q[7:0];
        cph_d[i] = cnt_q[15:8];
      end
      // hardware sets win over a software clear in the same cycle
      if (capt[i] || (match[i] && eff_mode[i][M_MAT]))
        ccf_d[i] = 1'b1;
    end
    if (adv && cnt_q == 16'hFFFF)
      cf_d = 1'b1;
    if (watchdog_enable_q && adv && cnt_q[7:0] == 8'hFF && cph_q[2] == cnt_q[15:8])
      wdt_reset_d = 1'b1;
    moved_d   = adv;
    lo_wrap_d = adv && cnt_q[7:0] == 8'hFF;
    wrap_d    = adv && cnt_q == 16'hFFFF;
    irq_d = (cf_q & ecf_q) |
            |(ccf_q & {mode_q[2][M_ECCF], mode_q[1][M_ECCF],
                       mode_q[0][M_ECCF]});
    rdata_d = 8'h00;
    if (sfr_addr == ADDR_CTL)
      rdata_d = {cf_q, run_q, 3'h0, ccf_q};
    if (sfr_addr == ADDR_MD)
      rdata_d = {idle_q, watchdog_enable_q, lock_q, 1'b0, tb_q, ecf_q};
    if (sfr_addr == ADDR_CNT_LO)
      rdata_d = cnt_q[7:0];
    if (sfr_addr == ADDR_CNT_HI)
      rdata_d = cnt_q[15:8];
    for (int i = 0; i < 3; i++)
    begin
      if (sfr_addr == ADDR_MODE[i])
        rdata_d = mode_q[i];
      if (sfr_addr == ADDR_CPH[i])
        rdata_d = cph_q[i];
      if (sfr_addr == ADDR_CPL[i])
        rdata_d = cpl_q[i];
    end
  end

  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      {cf_q, run_q, ccf_q} <= {RST_CTL[7:6], RST_CTL[2:0]};
      idle_q      <= RST_MD[MD_IDLE];
      watchdog_enable_q      <= RST_MD[MD_WATCHDOG_ENABLE];
      lock_q      <= RST_MD[MD_LOCK];
      tb_q        <= RST_MD[MD_TB_LSB+:3];
      ecf_q       <= RST_MD[MD_ECF];
      cnt_q       <= {RST_BYTE, RST_BYTE};
      for (int i = 0; i < 3; i++)
      begin
        mode_q[i] <= RST_BYTE;
        cpl_q[i]  <= RST_BYTE;
        cph_q[i]  <= RST_BYTE;
      end
      moved_q     <= 1'b0;
      lo_wrap_q   <= 1'b0;
      wrap_q      <= 1'b0;
      irq_q       <= 1'b0;
      wdt_reset_q <= 1'b0;
      sfr_rdata_q <= 8'h00;
    end
    else
    begin
      cf_q        <= cf_d;
      run_q       <= run_d;
      ccf_q       <= ccf_d;
      idle_q      <= idle_d;
      watchdog_enable_q      <= watchdog_enable_d;
      lock_q      <= lock_d;
      tb_q        <= tb_d;
      ecf_q       <= ecf_d;
      cnt_q       <= cnt_d;
      mode_q      <= mode_d;
      cpl_q       <= cpl_d;
      cph_q       <= cph_d;
      moved_q     <= moved_d;
      lo_wrap_q   <= lo_wrap_d;
      wrap_q      <= wrap_d;
      irq_q       <= irq_d;
      wdt_reset_q <= wdt_reset_d;
      sfr_rdata_q <= rdata_d;
    end
  end

  ovf_flag_set_a: assert property (
    @(posedge mclk) disable iff (!rst_n)
    adv && cnt_q == 16'hFFFF |=> cf_q && cnt_q == 16'h0000)
    else $error("overflow flag not set on wrap");

  flag_hold_a: assert property (
    @(posedge mclk) disable iff (!rst_n)
    cf_q && !ctl_wr |=> cf_q)
    else $error("overflow flag cleared without a write");

  irq_overflow_a: assert property (
    @(posedge mclk) disable iff (!rst_n)
    cf_q && ecf_q ##1 cf_q |-> irq_q)
    else $error("enabled overflow did not raise interrupt");

  run_hold_a: assert property (
    @(posedge mclk) disable iff (!rst_n)
    !run_q && !watchdog_enable_q && !cnt_wr |=> $stable(cnt_q))
    else $error("counter moved while stopped");

  idle_hold_a: assert property (
    @(posedge mclk) disable iff (!rst_n)
    idle_q && idle_mode && !cnt_wr |=> cnt_q == $past(cnt_q))
    else $error("counter moved in suspended idle");

  lock_keep_a: assert property (
    @(posedge mclk) disable iff (!rst_n)
    lock_q |=> lock_q && watchdog_enable_q)
    else $error("locked watchdog was disabled");

  mode_frozen_a: assert property (
    @(posedge mclk) disable iff (!rst_n)
    watchdog_enable_q && md_wr |=> $stable({idle_q, tb_q, ecf_q}))
    else $error("mode register changed under watchdog");

  unused_bit_a: assert property (
    @(posedge mclk) disable iff (!rst_n)
    sfr_addr == ADDR_MD |=> !sfr_rdata_q[MD_UNUSED])
    else $error("unused mode bit read as one");

  low_write_a: assert property (
    @(posedge mclk) disable iff (!rst_n)
    sfr_wr && sfr_addr == ADDR_CPL[0] |=> !mode_q[0][M_ECOM])
    else $error("low byte write left comparator on");

  wdt_fire_a: assert property (
    @(posedge mclk) disable iff (!rst_n)
    watchdog_enable_q && adv && cnt_q[7:0] == 8'hFF && cph_q[2] == cnt_q[15:8]
    |=> wdt_reset_q)
    else $error("watchdog match did not reset");
endmodule

/* tb/core_model.sv */
`timescale 1ns/1ps
module core_model
(
  // clock
  input  wire logic       mclk,
  // special function register bus
  output logic      [7:0] sfr_addr,
  output logic            sfr_wr,
  output logic      [7:0] sfr_wdata,
  input  wire logic [7:0] sfr_rdata_q,
  // core status
  output logic            idle_mode
);
  initial
  begin
    sfr_addr  = 8'h00;
    sfr_wr    = 1'b0;
    sfr_wdata = 8'h00;
    idle_mode = 1'b0;
  end

  // one-cycle strobe; data scrambled afterwards so nothing relies on it
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    sfr_addr  <= a;
    sfr_wdata <= d;
    sfr_wr    <= 1'b1;
    @(posedge mclk);
    sfr_wr    <= 1'b0;
    sfr_wdata <= ~d;
  endtask

  // read data is registered, so it is taken one edge after the address
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge mclk);
    sfr_addr <= a;
    @(posedge mclk);
    #1;
    d = sfr_rdata_q;
  endtask

  task automatic set_idle(input logic s);
    @(posedge mclk);
    idle_mode <= s;
  endtask
endmodule

/* tb/tb_top.sv */
`timescale 1ns/1ps
module tb_top;
  import counter_array_pkg::*;
  logic        mclk = 1'b0;
  logic        rst_n = 1'b0;
  logic [7:0]  sfr_addr;
  logic        sfr_wr;
  logic [7:0]  sfr_wdata;
  logic [7:0]  sfr_rdata_q;
  logic        idle_mode;
  logic        timer0_ovf = 1'b0;
  logic        eci_pin = 1'b1;
  logic        ext_clk_pin = 1'b0;
  logic [2:0]  cex_in = 3'h0;
  logic [2:0]  module_output_pin;
  logic        irq_q;
  logic        wdt_reset_q;
  logic [4:0]  gen = 5'h00;
  logic [7:0]  v;
  logic [7:0]  u;
  logic [15:0] h;
  int          n_fail = 0;
  int          num_checks = 0;
  logic [7:0]  rst_a [12] = '{ADDR_CTL, ADDR_MD, ADDR_MODE[0], ADDR_MODE[1],
    ADDR_MODE[2], ADDR_CPL[0], ADDR_CPH[0], ADDR_CPL[1], ADDR_CPL[2],
    ADDR_CPH[2], ADDR_CNT_HI, 8'h80};
  logic [15:0] tb_exp [7] = '{16'h0014, 16'h003C, 16'h000A, 16'h000A,
    16'h00F2, 16'h0005, 16'h0000};

  counter_array counter_array_inst (.mclk(mclk), .rst_n(rst_n),
    .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_wdata(sfr_wdata),
    .sfr_rdata_q(sfr_rdata_q), .idle_mode(idle_mode),
    .timer0_ovf(timer0_ovf), .eci_pin(eci_pin), .ext_clk_pin(ext_clk_pin),
    .cex_in(cex_in), .module_output_pin(module_output_pin),
    .irq_q(irq_q), .wdt_reset_q(wdt_reset_q));

  core_model core_model_inst (.mclk(mclk), .sfr_addr(sfr_addr),
    .sfr_wr(sfr_wr), .sfr_wdata(sfr_wdata), .sfr_rdata_q(sfr_rdata_q),
    .idle_mode(idle_mode));

  initial
  begin
    forever #2.5 mclk = ~mclk;
  end

  // 24-cycle pattern: eci falls once per pattern, far below quarter rate
  always @(posedge mclk)
  begin
    gen         <= (gen == 5'h17) ? 5'h00 : gen + 5'h01;
    timer0_ovf  <= (gen == 5'h00);
    eci_pin     <= (gen < 5'h0C);
    ext_clk_pin <= (gen % 6 < 3);
  end

  task automatic test_done();
    if (n_fail == 0 && num_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic check(input string what, input logic [15:0] seen,
                       input logic [15:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // counts seen through synchronisers may be off by a few steps
  task automatic near(input string what, input logic [15:0] seen,
                      input logic [15:0] exp, input logic [15:0] tol);
    check(what, {15'h0000, (seen + tol >= exp && seen <= exp + tol)},
          16'h0001);
  endtask

  task automatic w(input logic [7:0] a, input logic [7:0] d);
    core_model_inst.wr(a, d);
  endtask

  task automatic rd_chk(input string what, input logic [7:0] a,
                        input logic [7:0] exp);
    core_model_inst.rd(a, v);
    check(what, {8'h00, v}, {8'h00, exp});
  endtask

  task automatic wait_n(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask

  task automatic tb_count(input logic [2:0] code, input logic [15:0] exp);
    w(ADDR_CTL, 8'h00);
    w(ADDR_CNT_LO, 8'h00);
    w(ADDR_MD, {4'h0, code, 1'b0});
    w(ADDR_CTL, 8'h40);
    wait_n(240);
    w(ADDR_CTL, 8'h00);
    core_model_inst.rd(ADDR_CNT_LO, v);
    near("timebase steps", {8'h00, v}, exp, 16'h0004);
  endtask

  task automatic pwm_count(input logic [7:0] mode, input logic [7:0] cpl,
                           input logic [7:0] cph, input logic [15:0] exp);
    w(ADDR_CTL, 8'h00);
    w(ADDR_CNT_LO, 8'h00);
    w(ADDR_CNT_HI, 8'hFE);
    w(ADDR_CPL[0], cpl);
    w(ADDR_CPH[0], cph);
    w(ADDR_MODE[0], mode);
    w(ADDR_CTL, 8'h40);
    h = 16'h0000;
    repeat (512)
    begin
      @(posedge mclk);
      #1;
      h = h + {15'h0000, module_output_pin[0]};
    end
    near("pwm high cycles", h, exp, 16'h0008);
  endtask

  initial
  begin
    #100000;
    n_fail++;
    test_done();
  end

  initial
  begin
    repeat (12) @(posedge mclk);
    rst_n <= 1'b1;
    wait_n(2);
    foreach (rst_a[i])
      rd_chk("reset value", rst_a[i], (rst_a[i] == ADDR_MD) ? 8'h40 : 8'h00);
    w(ADDR_MD, 8'h4B);
    rd_chk("mode under watchdog", ADDR_MD, 8'h40);
    w(ADDR_MODE[2], 8'h48);
    rd_chk("module2 mode blocked", ADDR_MODE[2], 8'h00);
    w(ADDR_CNT_HI, 8'h12);
    rd_chk("counter write blocked", ADDR_CNT_HI, 8'h00);
    w(ADDR_MD, 8'h00);
    rd_chk("watchdog off", ADDR_MD, 8'h00);
    w(ADDR_MD, 8'h18);
    rd_chk("unused mode bit", ADDR_MD, 8'h08);
    w(ADDR_CTL, 8'h38);
    rd_chk("reserved control", ADDR_CTL, 8'h00);
    for (int i = 0; i < 7; i++)
      tb_count(3'(i), tb_exp[i]);
    w(ADDR_MD, 8'h08);
    w(ADDR_CTL, 8'h40);
    w(ADDR_CTL, 8'h00);
    core_model_inst.rd(ADDR_CNT_LO, u);
    wait_n(20);
    rd_chk("counter held", ADDR_CNT_LO, u);
    w(ADDR_MD, 8'h88);
    w(ADDR_CTL, 8'h40);
    core_model_inst.set_idle(1'b1);
    wait_n(4);
    core_model_inst.rd(ADDR_CNT_LO, u);
    wait_n(20);
    rd_chk("idle suspend", ADDR_CNT_LO, u);
    core_model_inst.set_idle(1'b0);
    w(ADDR_MD, 8'h08);
    w(ADDR_CTL, 8'h00);
    w(ADDR_CNT_LO, 8'hFD);
    w(ADDR_CNT_HI, 8'hFF);
    w(ADDR_CTL, 8'h40);
    wait_n(60);
    rd_chk("overflow flag", ADDR_CTL, 8'hC0);
    check("irq masked", {15'h0000, irq_q}, 16'h0000);
    w(ADDR_MD, 8'h09);
    wait_n(3);
    check("overflow irq", {15'h0000, irq_q}, 16'h0001);
    w(ADDR_CTL, 8'h40);
    rd_chk("flag cleared", ADDR_CTL, 8'h40);
    check("irq dropped", {15'h0000, irq_q}, 16'h0000);
    w(ADDR_MD, 8'h08);
    pwm_count(8'h42, 8'hC0, 8'hC0, 16'h0080);
    pwm_count(8'hC2, 8'hC0, 8'hFF, 16'h0040);
    w(ADDR_CTL, 8'h00);
    w(ADDR_CNT_LO, 8'h00);
    w(ADDR_CNT_HI, 8'h00);
    w(ADDR_MODE[0], 8'h0D);
    w(ADDR_CPL[0], 8'h40);
    w(ADDR_CPH[0], 8'h00);
    rd_chk("high sets compare", ADDR_MODE[0], 8'h4D);
    w(ADDR_CPL[0], 8'h40);
    rd_chk("low clears compare", ADDR_MODE[0], 8'h0D);
    w(ADDR_CPH[0], 8'h00);
    w(ADDR_CTL, 8'h40);
    wait_n(100);
    rd_chk("match flag", ADDR_CTL, 8'h41);
    check("toggled pin", {13'h0000, module_output_pin}, 16'h0001);
    check("match irq", {15'h0000, irq_q}, 16'h0001);
    w(ADDR_MODE[0], 8'h4C);
    wait_n(2);
    check("match irq masked", {15'h0000, irq_q}, 16'h0000);
    w(ADDR_MODE[1], 8'h10);
    @(posedge mclk);
    cex_in <= 3'h2;
    wait_n(10);
    rd_chk("rising ignored", ADDR_CTL, 8'h41);
    @(posedge mclk);
    cex_in <= 3'h0;
    wait_n(10);
    rd_chk("falling capture", ADDR_CTL, 8'h43);
    w(ADDR_CTL, 8'h00);
    w(ADDR_CNT_LO, 8'hF0);
    w(ADDR_CNT_HI, 8'h05);
    w(ADDR_CPL[2], 8'h00);
    w(ADDR_MD, 8'h48);
    w(ADDR_CPH[2], 8'h77);
    rd_chk("watchdog reload", ADDR_CPH[2], 8'h05);
    u = 8'h00;
    for (int i = 0; i < 300 && u == 8'h00; i++)
    begin
      @(posedge mclk);
      #1;
      if (wdt_reset_q === 1'b1)
        u = 8'h01;
    end
    check("watchdog reset", {8'h00, u}, 16'h0001);
    w(ADDR_MD, 8'h28);
    rd_chk("lock set", ADDR_MD, 8'h68);
    w(ADDR_MD, 8'h08);
    rd_chk("lock holds", ADDR_MD, 8'h68);
    @(posedge mclk);
    rst_n <= 1'b0;
    repeat (12) @(posedge mclk);
    rst_n <= 1'b1;
    wait_n(2);
    rd_chk("lock released", ADDR_MD, 8'h40);
    w(ADDR_MD, 8'h00);
    rd_chk("disable after reset", ADDR_MD, 8'h00);
    test_done();
  end
endmodule
